// *** inc/otp_lock_defines.vh ***
`ifndef OTP_LOCK_DEFINES_VH
`define OTP_LOCK_DEFINES_VH
// Register offsets (byte addresses)
`define OFS_FUSE_REGION_LOCK 8'h24
`define OFS_WATCHDOG_EVENT_TALLY 8'h28
`define OFS_IO_BANK_SUPPLY_LEVEL 8'h64
// Fuse lock register fields
`define BIT_TEST_FLAG 0
`define BIT_VENDOR_LOCK 1
`define BIT_PRIVATE_LOCK 2
`define BIT_USER_LOCK 3
`define BIT_PUBLIC_LOCK 4
// Tally field width
`define TALLY_W 4
// Supply register fields
`define BIT_BANK1_LEVEL 0
`define BIT_BANK2_LEVEL 1
`define BIT_SUPPLY_LOCK 7
// Fuse region byte bounds
`define PRIV_FIRST 9'h000
`define PRIV_LAST 9'h01f
`define VENDOR_FIRST 9'h020
`define VENDOR_LAST 9'h07f
`define PUBLIC_FIRST 9'h080
`define PUBLIC_LAST 9'h0bf
`define USER_FIRST 9'h0c0
`define USER_LAST 9'h1ff
`endif

// *** design/otp_lock_and_supply_config.v ***
// Contract
// - Public-key lock bit 4 blocks fuse bytes 128..191 when set.
// - User lock bit 3 blocks fuse bytes 192..511 when set.
// - Private-key lock bit 2 blocks fuse bytes 0..31 when set.
// - Vendor lock bit 1 blocks fuse bytes 32..127 when set.
// - Each lock bit takes one write, then ignores writes until reset.
// - Debug-port enable high blocks every protected fuse region.
// - Blocked fuse reads return a fixed constant in every bit.
// - Watchdog tally clears on power-on reset, kept over watchdog reset.
// - Supply lock 0: level bits and lock writable; 1: read-only.
// - Supply lock stays set until reset; writing zero does nothing.
// - Bank 1 level bit 0: 1 means 1.8V, 0 means 3.3V.
// - Bank 2 level bit 1: 1 means 1.8V, 0 means 3.3V.
// - Hardware loads level bits after standby power-on reset; the code skips the load while supply lock is set.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "otp_lock_defines.vh"
module otp_lock_and_supply_config #(
  parameter [7:0] FUSE_BLOCK_VALUE = 8'h00
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire por_reset_i,
  input wire debug_port_enable_i,
  input wire standby_por_load_i,
  input wire bank1_supply_i,
  input wire bank2_supply_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire [8:0] fuse_addr_i,
  input wire [7:0] fuse_data_i,
  input wire fuse_rd_i,
  output reg [7:0] fuse_rdata_o,
  output reg fuse_blocked_o,
  output reg bank1_supply_level_o,
  output reg bank2_supply_level_o
);

  // Lock bits live in the one-shot cells below
  wire public_lock_r;
  wire user_lock_r;
  wire private_lock_r;
  wire vendor_region_block_r;
  // Address decode of the four fuse regions
  wire in_private;
  wire in_vendor;
  wire in_public;
  wire in_user;
  reg [`TALLY_W-1:0] watchdog_expiry_tally_r;
  wire bank1_level_r;
  wire bank2_level_r;
  reg supply_lock_r;
  reg [31:0] rdata_nxt;
  reg blocked_nxt;

  wire wr_lock = wr_i && (addr_i == `OFS_FUSE_REGION_LOCK);
  wire wr_tally = wr_i && (addr_i == `OFS_WATCHDOG_EVENT_TALLY);
  wire wr_supply = wr_i && (addr_i == `OFS_IO_BANK_SUPPLY_LEVEL);

  // Lock cells: the first write to the register spends all four at once
  // Trade-off: a lock left clear by that write stays clear until reset
  // Debug gating sits in the read path, not in these cells
  // public-key lock cell
  one_shot_bit public_lock_inst (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .take_i(wr_lock),
    .data_i(wdata_i[`BIT_PUBLIC_LOCK]),
    .value_o(public_lock_r),
    .spent_o()
  );

  one_shot_bit user_lock_inst (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .take_i(wr_lock),
    .data_i(wdata_i[`BIT_USER_LOCK]),
    .value_o(user_lock_r),
    .spent_o()
  );

  one_shot_bit private_lock_inst (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .take_i(wr_lock),
    .data_i(wdata_i[`BIT_PRIVATE_LOCK]),
    .value_o(private_lock_r),
    .spent_o()
  );

  one_shot_bit vendor_lock_inst (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .take_i(wr_lock),
    .data_i(wdata_i[`BIT_VENDOR_LOCK]),
    .value_o(vendor_region_block_r),
    .spent_o()
  );

  // Tally survives system reset; only power-on reset clears it
  // power-on clear only
  always @(posedge clk_sys_i) begin
    if (por_reset_i) begin
      watchdog_expiry_tally_r <= {`TALLY_W{1'b0}};
    end else if (wr_tally) begin
      watchdog_expiry_tally_r <= wdata_i[`TALLY_W-1:0];
    end
  end

  wire level_write = wr_supply && !supply_lock_r;
  // locked levels also ignore the hardware load
  wire level_load = standby_por_load_i && !supply_lock_r;

  // Supply lock: set by software, cleared only by system reset
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      supply_lock_r <= 1'b0;
    end else if (level_write) begin
      supply_lock_r <= wdata_i[`BIT_SUPPLY_LOCK];
    end
  end

  level_cell bank1_level_inst (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .write_i(level_write),
    .wdata_i(wdata_i[`BIT_BANK1_LEVEL]),
    .load_i(level_load),
    .sensed_i(bank1_supply_i),
    .level_o(bank1_level_r)
  );

  level_cell bank2_level_inst (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .write_i(level_write),
    .wdata_i(wdata_i[`BIT_BANK2_LEVEL]),
    .load_i(level_load),
    .sensed_i(bank2_supply_i),
    .level_o(bank2_level_r)
  );

  // Level outputs mirror the register one cycle later
  // bank 1 and bank 2 levels
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      bank1_supply_level_o <= 1'b0;
      bank2_supply_level_o <= 1'b0;
    end else begin
      bank1_supply_level_o <= bank1_level_r;
      bank2_supply_level_o <= bank2_level_r;
    end
  end

  // Region decode: one window per region, together they tile the array
  // private-key window
  fuse_window #(
    .FIRST(`PRIV_FIRST),
    .LAST(`PRIV_LAST)
  ) private_window_inst (
    .fuse_addr_i(fuse_addr_i),
    .hit_o(in_private)
  );

  fuse_window #(
    .FIRST(`VENDOR_FIRST),
    .LAST(`VENDOR_LAST)
  ) vendor_window_inst (
    .fuse_addr_i(fuse_addr_i),
    .hit_o(in_vendor)
  );

  fuse_window #(
    .FIRST(`PUBLIC_FIRST),
    .LAST(`PUBLIC_LAST)
  ) public_window_inst (
    .fuse_addr_i(fuse_addr_i),
    .hit_o(in_public)
  );

  fuse_window #(
    .FIRST(`USER_FIRST),
    .LAST(`USER_LAST)
  ) user_window_inst (
    .fuse_addr_i(fuse_addr_i),
    .hit_o(in_user)
  );

  // Fuse region gating; debug port closes everything
  // Windows are exclusive, so at most one lock applies
  always @* begin
    blocked_nxt = 1'b0;
    if (in_private) begin
      blocked_nxt = private_lock_r;
    end
    if (in_vendor) begin
      blocked_nxt = vendor_region_block_r;
    end
    if (in_public) begin
      blocked_nxt = public_lock_r;
    end
    if (in_user) begin
      blocked_nxt = user_lock_r;
    end
    if (debug_port_enable_i) begin
      blocked_nxt = 1'b1;
    end
  end

  // Fuse read path, registered like the bus
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      fuse_rdata_o <= 8'h00;
      fuse_blocked_o <= 1'b0;
    end else if (fuse_rd_i) begin
      fuse_rdata_o <= blocked_nxt ? FUSE_BLOCK_VALUE : fuse_data_i;
      fuse_blocked_o <= blocked_nxt;
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (addr_i)
      `OFS_FUSE_REGION_LOCK: begin
        rdata_nxt[`BIT_TEST_FLAG] = 1'b0;
        rdata_nxt[`BIT_VENDOR_LOCK] = vendor_region_block_r;
        rdata_nxt[`BIT_PRIVATE_LOCK] = private_lock_r;
        rdata_nxt[`BIT_USER_LOCK] = user_lock_r;
        rdata_nxt[`BIT_PUBLIC_LOCK] = public_lock_r;
      end
      `OFS_WATCHDOG_EVENT_TALLY: begin
        rdata_nxt[`TALLY_W-1:0] = watchdog_expiry_tally_r;
      end
      `OFS_IO_BANK_SUPPLY_LEVEL: begin
        rdata_nxt[`BIT_BANK1_LEVEL] = bank1_level_r;
        rdata_nxt[`BIT_BANK2_LEVEL] = bank2_level_r;
        rdata_nxt[`BIT_SUPPLY_LOCK] = supply_lock_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data valid the cycle after the strobe, zero otherwise
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule // otp_lock_and_supply_config

// Write-once register cell: the first write lands, later writes bounce
// off until system reset; W lets one cell hold a whole field
module one_shot_bit #(
  parameter W = 1
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire take_i,
  input wire [W-1:0] data_i,
  output reg [W-1:0] value_o,
  output reg spent_o
);

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      value_o <= {W{1'b0}};
      spent_o <= 1'b0;
    end else if (take_i) begin
      // Spent even when the data is zero
      if (!spent_o) begin
        value_o <= data_i;
      end
      spent_o <= 1'b1;
    end
  end

endmodule // one_shot_bit

// Address window over the fuse array; both bounds inclusive
module fuse_window #(
  parameter [8:0] FIRST = `PRIV_FIRST,
  parameter [8:0] LAST = `USER_LAST
) (
  input wire [8:0] fuse_addr_i,
  output wire hit_o
);

  // Pure decode, no state; the caller registers the result
  assign hit_o = (fuse_addr_i >= FIRST) && (fuse_addr_i <= LAST);

endmodule // fuse_window

// Level cell: a software write beats the standby load in one cycle
module level_cell #(
  parameter W = 1
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire write_i,
  input wire [W-1:0] wdata_i,
  input wire load_i,
  input wire [W-1:0] sensed_i,
  output reg [W-1:0] level_o
);

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      level_o <= {W{1'b0}};
    end else if (write_i) begin
      level_o <= wdata_i;
    end else if (load_i) begin
      level_o <= sensed_i;
    end
  end

endmodule // level_cell

// *** bench/otp_lock_and_supply_config_assertions.sv ***
`timescale 1ns/1ps
module otp_chk #(parameter [7:0] FUSE_BLOCK_VALUE = 8'h00) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire por_reset_i,
  input wire debug_port_enable_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire fuse_rd_i,
  input wire [7:0] fuse_rdata_o,
  input wire fuse_blocked_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Reads by offset
  wire tl = rd_i && addr_i == 8'h28;
  wire sp = rd_i && addr_i == 8'h64;
  rd_idle_a: assert property (!rd_i |=> !rdata_o) else $error("rdata not idle");
  lock_spare_a: assert property (rd_i && addr_i == 8'h24 |=> !rdata_o[31:5] && !rdata_o[0])
    else $error("lock spare bits");
  por_clear_a: assert property (por_reset_i && !wr_i ##1 tl |=> !rdata_o) else $error("tally kept");
  supply_spare_a: assert property (sp |=> !rdata_o[31:8] && !rdata_o[6:2]) else $error("supply spare");
  // Lock holds over two reads two cycles apart, so may not the levels move
  lock_stay_a: assert property (sp ##1 rdata_o[7] ##1 sp |=> rdata_o[7] && rdata_o[1:0] == $past(rdata_o[1:0], 2))
    else $error("supply lock lost");
  dbg_block_a: assert property (fuse_rd_i && debug_port_enable_i |=> fuse_blocked_o) else $error("debug open");
  blk_value_a: assert property (fuse_blocked_o |-> fuse_rdata_o == FUSE_BLOCK_VALUE) else $error("blocked data");
  fuse_hold_a: assert property (!fuse_rd_i && !reset_i |=> $stable(fuse_rdata_o) && $stable(fuse_blocked_o))
    else $error("fuse moved");
endmodule // otp_chk
bind otp_lock_and_supply_config otp_chk #(.FUSE_BLOCK_VALUE(FUSE_BLOCK_VALUE)) otp_chk_inst (.clk_sys_i(clk_sys_i),
  .reset_i(reset_i), .por_reset_i(por_reset_i), .debug_port_enable_i(debug_port_enable_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fuse_rd_i(fuse_rd_i), .fuse_rdata_o(fuse_rdata_o),
  .fuse_blocked_o(fuse_blocked_o));

// *** bench/test_otp_lock_and_supply_config.sv ***
`timescale 1ns/1ps
module test_otp_lock_and_supply_config;
  reg clk_sys_i = 0, reset_i = 1, por_reset_i = 1, debug_port_enable_i = 0, standby_por_load_i = 0;
  reg bank1_supply_i = 0, bank2_supply_i = 0, wr_i = 0, rd_i = 0, fuse_rd_i = 0;
  reg [7:0] addr_i = 0, fuse_data_i = 0;
  reg [8:0] fuse_addr_i = 0;
  reg [31:0] wdata_i = 0, v, k;
  wire [31:0] rdata_o;
  wire [7:0] fuse_rdata_o;
  wire fuse_blocked_o, bank1_supply_level_o, bank2_supply_level_o;
  integer err_count = 0, samples_checked = 0, seed = 32'h47eb_fff0, cyc = 0, i, j;
  localparam [71:0] EDGES = {9'h1ff, 9'h0c0, 9'h0bf, 9'h080, 9'h07f, 9'h020, 9'h01f, 9'h000};
  otp_lock_and_supply_config otp_lock_and_supply_config_inst (.*);
  initial forever #25 clk_sys_i = ~clk_sys_i;
  // Hang guard, the run needs some 260 cycles
  always @(posedge clk_sys_i) if (cyc++ == 3000) begin
    err_count = err_count + 1;
    test_done;
  end
  task tk;
    @(posedge clk_sys_i);
  endtask
  task chk(input [31:0] n, e, g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %s exp %h got %h", n, e, g);
      end
    end
  endtask
  // One strobe, then an idle cycle in which the answer stands
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      {addr_i, wdata_i, wr_i, rd_i} <= {a, d, w, !w};
      tk;
      {wr_i, rd_i} <= 0;
      #1 if (!w) chk("reg", d, rdata_o);
      tk;
    end
  endtask
  function bf(input [8:0] a, input [4:0] m);
    bf = debug_port_enable_i | (a < 32 ? m[2] : a < 128 ? m[1] : a < 192 ? m[4] : m[3]);
  endfunction
  // Region edges first, then random fuse bytes
  task sweep(input [4:0] m);
    for (i = 0; i < 12; i = i + 1) begin
      v = i < 8 ? EDGES[i*9+:9] : $random(seed);
      {fuse_addr_i, fuse_data_i, fuse_rd_i} <= {v[8:0], 8'($random(seed)), 1'b1};
      tk;
      fuse_rd_i <= 0;
      #1 chk("fuse", bf(v[8:0], m) ? 9'h100 : fuse_data_i, {fuse_blocked_o, fuse_rdata_o});
      tk;
    end
  endtask
  task test_done;
    begin
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) tk;
    {reset_i, por_reset_i} <= 0;
    bus(0, 8'h24, 0);
    bus(0, 8'h64, 0);
    bus(0, 8'h30, 0);
    v = $random(seed);
    bus(1, 8'h28, v);
    reset_i <= 1;
    tk;
    reset_i <= 0;
    bus(0, 8'h28, v & 15);
    por_reset_i <= 1;
    tk;
    por_reset_i <= 0;
    bus(0, 8'h28, 0);
    $display("tally tests done");
    // Locks: none, all, random, random with debug port on
    for (j = 0; j < 4; j = j + 1) begin
      {reset_i, debug_port_enable_i} <= {1'b1, j == 3};
      tk;
      reset_i <= 0;
      k = j == 0 ? 0 : j == 1 ? ~0 : $random(seed);
      sweep(0);
      bus(1, 8'h24, k);
      bus(1, 8'h24, ~k);
      bus(0, 8'h24, k & 30);
      sweep(k[4:0]);
    end
    $display("lock tests done");
    // Standby load, then locked levels shrug off writes and loads
    v = $random(seed);
    {bank2_supply_i, bank1_supply_i, standby_por_load_i} <= {v[1:0], 1'b1};
    tk;
    standby_por_load_i <= 0;
    bus(0, 8'h64, v & 3);
    bus(1, 8'h64, ~v & 3);
    bus(0, 8'h64, ~v & 3);
    bus(1, 8'h64, 0);
    bus(0, 8'h64, 0);
    bus(1, 8'h64, 32'h0000_0081 ^ v & 3);
    bus(1, 8'h64, 32'h0000_0002 ^ v & 3);
    standby_por_load_i <= 1;
    tk;
    standby_por_load_i <= 0;
    bus(0, 8'h64, 32'h0000_0081 ^ v & 3);
    bus(0, 8'h64, 32'h0000_0081 ^ v & 3);
    #1 chk("lvl", 1 ^ v & 3, {bank2_supply_level_o, bank1_supply_level_o});
    tk;
    reset_i <= 1;
    tk;
    reset_i <= 0;
    bus(0, 8'h64, 0);
    $display("supply tests done");
    test_done;
  end
endmodule // test_otp_lock_and_supply_config
